// file: design/drc_top.sv
// Reset, clear-code and reference control of a dual-channel serial DAC.
// Assumes pins arrive asynchronously; the bus clock is sampled by ref_clk.
`timescale 1ns/1ps

module drc_top
    import drc_pkg::*;
(
    // Clock and power-on reset.
    input  wire logic           ref_clk,
    input  wire logic           arst_n,
    // Two-wire link.
    input  wire logic           scl,
    input  wire logic           sda_in,
    output logic                sda_out,
    output logic                sda_oe,
    // Control pins.
    input  wire logic           hw_reset_n,
    input  wire logic           reset_level_select,
    input  wire logic           load_strobe_n,
    // Converter codes and state.
    output logic [11:0]         analog_output_a_code,
    output logic [11:0]         analog_output_b_code,
    output logic                reference_off,
    output logic                por_busy
);

    // ****************************************************************
    // Pin synchronisation
    // ****************************************************************
    drc_pins_t pins_raw;
    drc_pins_t pins_f;

    assign pins_raw = '{scl, sda_in, hw_reset_n, reset_level_select,
                        load_strobe_n};

    drc_sync3 #(
        .W         ($bits(drc_pins_t)),
        .RESET_VAL (PINS_RESET)
    ) u_sync (
        .ref_clk  (ref_clk),
        .arst_n   (arst_n),
        .async_in (pins_raw),
        .filt_out (pins_f)
    );

    // ****************************************************************
    // Edge detection on filtered pins
    // ****************************************************************
    drc_pins_t prev_q;

    // Previous filtered levels, for edges and bus conditions.
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            prev_q <= PINS_RESET;
        end else begin
            prev_q <= pins_f;
        end
    end

    logic scl_rise;
    logic scl_fall;
    logic bus_start;
    logic bus_stop;

    assign scl_rise  = pins_f.scl & ~prev_q.scl;
    assign scl_fall  = ~pins_f.scl & prev_q.scl;
    assign bus_start = pins_f.scl & prev_q.scl & prev_q.sda & ~pins_f.sda;
    assign bus_stop  = pins_f.scl & prev_q.scl & ~prev_q.sda & pins_f.sda;

    // ****************************************************************
    // Power-on sequence
    // ****************************************************************
    logic [POR_CNT_W-1:0] por_cnt_q;
    logic                 por_busy_q;
    logic                 frame_valid_q;
    drc_frame_t           frame_q;
    logic                 soft_reset;

    assign soft_reset = frame_valid_q && (frame_q.cmd == CMD_SOFT_RESET);

    // A soft reset replays the whole power-on sequence.
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            por_cnt_q  <= POR_CNT_W'(POR_CYCLES);
            por_busy_q <= 1'b1;
        end else if (soft_reset) begin
            por_cnt_q  <= POR_CNT_W'(POR_CYCLES);
            por_busy_q <= 1'b1;
        end else if (por_cnt_q != '0) begin
            por_cnt_q  <= por_cnt_q - 1'b1;
            por_busy_q <= (por_cnt_q != POR_CNT_W'(1));
        end
    end

    assign por_busy = por_busy_q;

    // Pin events count only once power-on reset is over.
    logic hw_rst;
    logic load_strobe_n_fall;

    assign hw_rst    = ~pins_f.reset_n & ~por_busy_q;
    assign load_strobe_n_fall = prev_q.load_strobe_n & ~pins_f.load_strobe_n
                       & ~por_busy_q & ~hw_rst;

    // ****************************************************************
    // Link receiver
    // ****************************************************************
    drc_link_state_t state_q;
    logic [2:0]      bit_cnt_q;
    logic [7:0]      byte_q;
    logic [4:0]      frame_bits_q;
    logic [23:0]     frame_sh_q;
    logic            ack_drive_q;

    // Frames run back to back; an early stop discards a partial frame.
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            state_q      <= LS_IDLE;
            bit_cnt_q    <= 3'h0;
            byte_q       <= 8'h00;
            frame_bits_q <= 5'h00;
            frame_sh_q   <= 24'h000000;
            ack_drive_q  <= 1'b0;
        end else if (bus_start) begin
            state_q      <= LS_ADDR;
            bit_cnt_q    <= 3'h0;
            frame_bits_q <= 5'h00;
            ack_drive_q  <= 1'b0;
        end else if (bus_stop) begin
            state_q     <= LS_IDLE;
            ack_drive_q <= 1'b0;
        end else begin
            unique case (state_q)
                LS_IDLE: begin
                    ack_drive_q <= 1'b0;
                end
                LS_ADDR: begin
                    if (scl_rise) begin
                        byte_q    <= {byte_q[6:0], pins_f.sda};
                        bit_cnt_q <= bit_cnt_q + 3'h1;
                        if (bit_cnt_q == 3'h7) begin
                            // Reads and other addresses are not answered.
                            if (byte_q[6:0] == DEV_ADDR && !pins_f.sda) begin
                                state_q <= LS_ADDR_ACK;
                            end else begin
                                state_q <= LS_IDLE;
                            end
                        end
                    end
                end
                LS_ADDR_ACK, LS_DATA_ACK: begin
                    if (scl_fall) begin
                        ack_drive_q <= ~ack_drive_q;
                        if (ack_drive_q) begin
                            state_q <= LS_DATA;
                        end
                    end
                end
                LS_DATA: begin
                    if (scl_rise) begin
                        frame_sh_q <= {frame_sh_q[22:0], pins_f.sda};
                        bit_cnt_q  <= bit_cnt_q + 3'h1;
                        if (frame_bits_q == 5'(FRAME_BITS - 1)) begin
                            frame_bits_q <= 5'h00;
                        end else begin
                            frame_bits_q <= frame_bits_q + 5'h01;
                        end
                        if (bit_cnt_q == 3'h7) begin
                            state_q <= LS_DATA_ACK;
                        end
                    end
                end
            endcase
        end
    end

    // Frame is handed on only when its 24th bit has been sampled.
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            frame_valid_q <= 1'b0;
            frame_q       <= '0;
        end else begin
            frame_valid_q <= (state_q == LS_DATA) && scl_rise && !bus_stop
                && !bus_start && frame_bits_q == 5'(FRAME_BITS - 1);
            if (state_q == LS_DATA && scl_rise) begin
                frame_q <= drc_frame_t'({frame_sh_q[22:0], pins_f.sda});
            end
        end
    end

    assign sda_out = 1'b0;
    assign sda_oe  = ack_drive_q;

    // ****************************************************************
    // Mask and reference control
    // ****************************************************************
    logic [1:0] mask_q;
    logic       ref_off_q;

    // Reference stays on through power-on; hardware reset leaves it alone.
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            mask_q    <= MASK_RESET;
            ref_off_q <= REF_CTRL_RESET;
        end else if (por_busy_q) begin
            mask_q    <= MASK_RESET;
            ref_off_q <= REF_CTRL_RESET;
        end else if (frame_valid_q) begin
            if (frame_q.cmd == CMD_REF_SETUP) begin
                ref_off_q <= frame_q.data[REF_CTRL_POS];
            end
            if (frame_q.cmd == CMD_LOAD_MASK) begin
                mask_q <= {frame_q.data[CH_B_POS], frame_q.data[CH_A_POS]};
            end
        end
    end

    assign reference_off = ref_off_q;

    // ****************************************************************
    // Channel registers
    // ****************************************************************
    logic [11:0] inp_q [2];
    logic [11:0] dac_q [2];
    logic [11:0] clr;

    assign clr = clear_code(pins_f.level_sel);

    genvar ch;
    generate
        for (ch = 0; ch < 2; ch++) begin : g_ch
            logic        hit;
            logic [11:0] code;
            assign hit  = frame_q.addr[ch_bit(ch)];
            assign code = frame_q.data[CODE_LSB +: CODE_W];

            // Any reset clears both banks so a later strobe finds no
            // stale data. Writes land before a strobe in the same cycle.
            always_ff @(posedge ref_clk or negedge arst_n) begin
                if (!arst_n) begin
                    inp_q[ch] <= ZERO_SCALE;
                    dac_q[ch] <= ZERO_SCALE;
                end else if (por_busy_q || soft_reset) begin
                    inp_q[ch] <= clr;
                    dac_q[ch] <= clr;
                end else if (hw_rst) begin
                    inp_q[ch] <= clr;
                    dac_q[ch] <= clr;
                end else if (frame_valid_q && hit
                             && frame_q.cmd == CMD_WRITE_INPUT) begin
                    inp_q[ch] <= code;
                    if (!pins_f.load_strobe_n) begin
                        dac_q[ch] <= code;
                    end
                end else if (frame_valid_q && hit
                             && frame_q.cmd == CMD_UPDATE_DAC) begin
                    dac_q[ch] <= inp_q[ch];
                end else if (frame_valid_q && hit
                             && frame_q.cmd == CMD_WRITE_UPDATE) begin
                    inp_q[ch] <= code;
                    dac_q[ch] <= code;
                end else if (load_strobe_n_fall && !mask_q[ch]) begin
                    dac_q[ch] <= inp_q[ch];
                end
            end
        end
    endgenerate

    assign analog_output_a_code = dac_q[0];
    assign analog_output_b_code = dac_q[1];

    // ****************************************************************
    // Assertions
    // ****************************************************************
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!arst_n);

    logic quiet;
    assign quiet = !por_busy_q && !hw_rst && !frame_valid_q && !load_strobe_n_fall;

    property p_hw_clear;
        hw_rst |=> dac_q[0] == clear_code($past(pins_f.level_sel))
                   && dac_q[1] == clear_code($past(pins_f.level_sel));
    endproperty
    a_hw_clear: assert property (p_hw_clear)
        else $error("outputs not cleared under reset pin");

    property p_hold_after;
        quiet |=> $stable(dac_q[0]) && $stable(dac_q[1]);
    endproperty
    a_hold_after: assert property (p_hold_after)
        else $error("output changed with no cause");

    property p_block_update;
        hw_rst && frame_valid_q |=> dac_q[0] == $past(clr)
                                    && dac_q[1] == $past(clr);
    endproperty
    a_block_update: assert property (p_block_update)
        else $error("write reached output during reset pin");

    property p_soft_reset;
        soft_reset |=> por_busy_q && por_cnt_q == POR_CNT_W'(POR_CYCLES)
                       && dac_q[0] == $past(clr) && !frame_valid_q;
    endproperty
    a_soft_reset: assert property (p_soft_reset)
        else $error("soft reset did not restart power-on");

    // Pin activity must neither act nor stall the power-on count.
    property p_por_ignore;
        por_busy_q && !soft_reset
            && (!pins_f.reset_n || !pins_f.load_strobe_n)
            |-> !load_strobe_n_fall && !hw_rst
            ##1 por_cnt_q == $past(por_cnt_q) - POR_CNT_W'(1);
    endproperty
    a_por_ignore: assert property (p_por_ignore)
        else $error("pin event seen during power-on reset");

    property p_por_level;
        $fell(por_busy_q) |-> dac_q[1] == clear_code($past(pins_f.level_sel))
                              && inp_q[0] == dac_q[0];
    endproperty
    a_por_level: assert property (p_por_level)
        else $error("power-up level wrong");

    property p_ref_write;
        frame_valid_q && !por_busy_q && frame_q.cmd == CMD_REF_SETUP
            |=> reference_off == $past(frame_q.data[REF_CTRL_POS]);
    endproperty
    a_ref_write: assert property (p_ref_write)
        else $error("reference bit not loaded");

    property p_ref_default;
        $fell(por_busy_q) |-> !reference_off && mask_q == MASK_RESET;
    endproperty
    a_ref_default: assert property (p_ref_default)
        else $error("reference not on after power-on");

    property p_strobe;
        load_strobe_n_fall && !mask_q[0] && !frame_valid_q
            |=> dac_q[0] == $past(inp_q[0]);
    endproperty
    a_strobe: assert property (p_strobe)
        else $error("falling strobe did not load channel");

    property p_frame_end;
        frame_valid_q |-> $past(frame_bits_q) == 5'(FRAME_BITS - 1)
                          && $past(state_q) == LS_DATA;
    endproperty
    a_frame_end: assert property (p_frame_end)
        else $error("frame acted before its last bit");

    property p_clear_both;
        hw_rst |=> inp_q[0] == dac_q[0] && inp_q[1] == dac_q[1];
    endproperty
    a_clear_both: assert property (p_clear_both)
        else $error("input register kept stale data");

    c_soft_reset: cover property (soft_reset);
    c_hw_reset:   cover property (hw_rst ##1 !hw_rst);
    c_strobe:     cover property (load_strobe_n_fall && !mask_q[1]);
    c_ref_off:    cover property (frame_valid_q && frame_q.data[0]
                                  && frame_q.cmd == CMD_REF_SETUP);

endmodule : drc_top

// file: design/drc_pkg.sv
// Shared constants, types and helpers of the DAC reset and reference block.
// Assumes a 100 MHz ref_clk and 24-bit command frames over a two-wire link.
package drc_pkg;

    // ****************************************************************
    // Timing
    // ****************************************************************
    localparam int CLK_PERIOD_NS = 10;
    // Length of the power-on clear sequence; a plain default.
    localparam int POR_TIME_NS   = 1000;
    localparam int POR_CYCLES    =
        (POR_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int POR_CNT_W     = 8;

    // ****************************************************************
    // Commands, frame layout and codes
    // ****************************************************************
    localparam logic [3:0] CMD_WRITE_INPUT  = 4'h1;
    localparam logic [3:0] CMD_UPDATE_DAC   = 4'h2;
    localparam logic [3:0] CMD_WRITE_UPDATE = 4'h3;
    localparam logic [3:0] CMD_LOAD_MASK    = 4'h5;
    localparam logic [3:0] CMD_SOFT_RESET   = 4'h6;
    localparam logic [3:0] CMD_REF_SETUP    = 4'h7;

    localparam int FRAME_BITS   = 24;
    localparam int CODE_W       = 12;
    localparam int CODE_LSB     = 4;
    localparam int CH_A_POS     = 0;
    localparam int CH_B_POS     = 3;
    localparam int REF_CTRL_POS = 0;

    localparam logic [11:0] ZERO_SCALE     = 12'h000;
    localparam logic [11:0] MID_SCALE      = 12'h800;
    localparam logic        REF_CTRL_RESET = 1'b0;
    localparam logic [1:0]  MASK_RESET     = 2'h0;
    // Bus address of the device; the value is arbitrary.
    localparam logic [6:0]  DEV_ADDR       = 7'h0C;

    // Fields of one command frame, most significant bit sent first.
    typedef struct packed {
        logic [3:0]  cmd;
        logic [3:0]  addr;
        logic [15:0] data;
    } drc_frame_t;

    // Pins from outside the clock domain, carried together.
    typedef struct packed {
        logic scl;
        logic sda;
        logic reset_n;
        logic level_sel;
        logic load_strobe_n;
    } drc_pins_t;

    localparam drc_pins_t PINS_RESET = '{1'b1, 1'b1, 1'b1, 1'b0, 1'b1};

    typedef enum {
        LS_IDLE,
        LS_ADDR,
        LS_ADDR_ACK,
        LS_DATA,
        LS_DATA_ACK
    } drc_link_state_t;

    // Clear code picked by the reset level select input.
    function automatic logic [11:0] clear_code(input logic sel);
        clear_code = sel ? MID_SCALE : ZERO_SCALE;
    endfunction : clear_code

    // Bit that names a channel in the address and mask fields.
    function automatic int ch_bit(input int ch);
        ch_bit = (ch == 0) ? CH_A_POS : CH_B_POS;
    endfunction : ch_bit

endpackage : drc_pkg

// file: design/drc_sync3.sv
// Three-stage input synchroniser with an agreement filter.
// Assumes asynchronous inputs; output follows once stages two and three agree.
`timescale 1ns/1ps
module drc_sync3
    import drc_pkg::*;
#(
    parameter int               W         = 1,
    parameter logic [W-1:0]     RESET_VAL = '0
) (
    // Clock and reset.
    input  wire logic           ref_clk,
    input  wire logic           arst_n,
    // Raw and filtered levels.
    input  wire logic [W-1:0]   async_in,
    output logic      [W-1:0]   filt_out
);

    // ****************************************************************
    // One chain per bit
    // ****************************************************************
    genvar g;
    generate
        for (g = 0; g < W; g++) begin : g_bit
            logic s1_q;
            logic s2_q;
            logic s3_q;
            logic f_q;
            // Stage one feeds only stage two, so no metastable value leaks.
            always_ff @(posedge ref_clk or negedge arst_n) begin
                if (!arst_n) begin
                    s1_q <= RESET_VAL[g];
                    s2_q <= RESET_VAL[g];
                    s3_q <= RESET_VAL[g];
                    f_q  <= RESET_VAL[g];
                end else begin
                    s1_q <= async_in[g];
                    s2_q <= s1_q;
                    s3_q <= s2_q;
                    if (s2_q == s3_q) begin
                        f_q <= s3_q;
                    end
                end
            end
            assign filt_out[g] = f_q;
        end
    endgenerate

endmodule : drc_sync3

// file: sim/drc_i2c_host.sv
// Behavioural two-wire host that sends command frames to the converter.
// Assumes an open-drain data line with a pull-up built by the bench.
`timescale 1ns/1ps
module drc_i2c_host (
    // Link pins.
    output logic                scl,
    output logic                sda_low,
    input  wire logic           sda_line
);
    // Link clock of 160 ns; it stands high between transfers.
    localparam int HALF_NS = 80;
    localparam int QTR_NS  = 40;

    initial begin
        scl     = 1'b1;
        sda_low = 1'b0;
    end

    // Data only moves while the clock is low, so no false start or stop.
    task automatic put_bit(input logic b);
        sda_low = ~b;
        #QTR_NS;
        scl = 1'b1;
        #HALF_NS;
        scl = 1'b0;
        #QTR_NS;
    endtask : put_bit

    // Release the line and sample the answer in mid high phase.
    task automatic get_ack(output logic a);
        sda_low = 1'b0;
        #QTR_NS;
        scl = 1'b1;
        #QTR_NS;
        a = ~sda_line;
        #QTR_NS;
        scl = 1'b0;
        #QTR_NS;
    endtask : get_ack

    // Start, address byte, nbytes of the frame, stop; short counts abort.
    task automatic xfer(input logic [6:0] dev, input logic [23:0] frame,
                        input int nbytes, output logic acked);
        logic [31:0] bits;
        logic        a;
        bits    = {dev, 1'b0, frame};
        acked   = 1'b1;
        sda_low = 1'b1;
        #QTR_NS;
        scl = 1'b0;
        #QTR_NS;
        for (int i = 0; i <= nbytes; i++) begin
            for (int j = 31 - 8 * i; j > 23 - 8 * i; j--) begin
                put_bit(bits[j]);
            end
            get_ack(a);
            acked = acked & a;
            if (!a) break;
        end
        sda_low = 1'b1;
        #QTR_NS;
        scl = 1'b1;
        #QTR_NS;
        sda_low = 1'b0;
        #HALF_NS;
    endtask : xfer
endmodule : drc_i2c_host

// file: sim/drc_top_tb_top.sv
// Self-checking bench of the reset and reference control block.
// Assumes the host model above and a pull-up on the data line.
`timescale 1ns/1ps
module drc_top_tb_top;
    import drc_pkg::*;

    localparam int TMO = 40000;

    logic        ref_clk, arst_n, hw_reset_n, reset_level_select;
    logic        load_strobe_n, scl, sda_low, sda_out, sda_oe;
    logic        reference_off, por_busy, ak;
    logic [11:0] code_a, code_b;
    wire         sda_line = !(sda_low || (sda_oe && !sda_out));
    int          n_mismatch, check_count, cyc;

    drc_top drc_top_i (.ref_clk(ref_clk), .arst_n(arst_n), .scl(scl),
        .sda_in(sda_line), .sda_out(sda_out), .sda_oe(sda_oe),
        .hw_reset_n(hw_reset_n), .reset_level_select(reset_level_select),
        .load_strobe_n(load_strobe_n), .analog_output_a_code(code_a),
        .analog_output_b_code(code_b), .reference_off(reference_off),
        .por_busy(por_busy));

    drc_i2c_host drc_i2c_host_i (.scl(scl), .sda_low(sda_low),
        .sda_line(sda_line));

    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end

    // A hang counts as a mismatch and ends the run.
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == TMO) begin
            n_mismatch++;
            complete_run();
        end
    end

    task automatic complete_run();
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : complete_run

    task automatic check(input string what, input logic [11:0] exp,
                         input logic [11:0] got);
        check_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask : check

    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask : tick

    // Bounded wait for the clear sequence to finish.
    task automatic wait_por();
        for (int i = 0; i < 300 && por_busy !== 1'b0; i++) tick(1);
        check("por_busy", 12'h000, 12'(por_busy));
    endtask : wait_por

    // One frame; effects land a few cycles after the last clock edge.
    task automatic frame(input logic [3:0] cmd, input logic [3:0] adr,
                         input logic [15:0] data, input int nb,
                         input logic exp_ack);
        drc_i2c_host_i.xfer(DEV_ADDR, {cmd, adr, data}, nb, ak);
        check("ack", 12'(exp_ack), 12'(ak));
        tick(10);
    endtask : frame

    task automatic strobe();
        load_strobe_n = 1'b0;
        tick(8);
        load_strobe_n = 1'b1;
        tick(8);
    endtask : strobe

    task automatic codes(input logic [11:0] ea, input logic [11:0] eb);
        check("code_a", ea, code_a);
        check("code_b", eb, code_b);
    endtask : codes

    // ****************************************************************
    // Test sequence
    // ****************************************************************
    initial begin
        arst_n = 1'b0;
        hw_reset_n = 1'b1;
        reset_level_select = 1'b1;
        load_strobe_n = 1'b1;
        tick(4);
        arst_n = 1'b1;
        tick(2);
        // Pin events during power-on clear must not disturb it.
        hw_reset_n = 1'b0;
        load_strobe_n = 1'b0;
        tick(10);
        hw_reset_n = 1'b1;
        load_strobe_n = 1'b1;
        tick(10);
        check("por_busy", 12'h001, 12'(por_busy));
        wait_por();
        codes(MID_SCALE, MID_SCALE);
        check("ref_off", 12'h000, 12'(reference_off));
        $display("test power_on done");

        frame(CMD_WRITE_UPDATE, 4'h1, 16'h1230, 3, 1'b1);
        codes(12'h123, MID_SCALE);
        frame(CMD_WRITE_UPDATE, 4'h1, 16'hABC0, 2, 1'b1);
        codes(12'h123, MID_SCALE);
        frame(CMD_WRITE_INPUT, 4'h8, 16'h4560, 3, 1'b1);
        codes(12'h123, MID_SCALE);
        strobe();
        codes(12'h123, 12'h456);
        drc_i2c_host_i.xfer(DEV_ADDR ^ 7'h01, 24'h3112_30, 3, ak);
        tick(10);
        check("ack_other", 12'h000, 12'(ak));
        codes(12'h123, 12'h456);
        $display("test write done");

        frame(CMD_REF_SETUP, 4'hF, 16'h0001, 3, 1'b1);
        check("ref_off", 12'h001, 12'(reference_off));
        frame(CMD_REF_SETUP, 4'h0, 16'hFFFE, 3, 1'b1);
        check("ref_off", 12'h000, 12'(reference_off));
        $display("test reference done");

        reset_level_select = 1'b0;
        hw_reset_n = 1'b0;
        tick(10);
        codes(ZERO_SCALE, ZERO_SCALE);
        frame(CMD_WRITE_UPDATE, 4'h9, 16'h7770, 3, 1'b1);
        strobe();
        codes(ZERO_SCALE, ZERO_SCALE);
        hw_reset_n = 1'b1;
        tick(10);
        codes(ZERO_SCALE, ZERO_SCALE);
        strobe();
        codes(ZERO_SCALE, ZERO_SCALE);
        frame(CMD_WRITE_UPDATE, 4'h1, 16'h5A50, 3, 1'b1);
        codes(12'h5A5, ZERO_SCALE);
        $display("test hw_reset done");

        // Mask channel B, then strobe, update command and a held strobe.
        frame(CMD_LOAD_MASK, 4'h0, 16'h0008, 3, 1'b1);
        frame(CMD_WRITE_INPUT, 4'h9, 16'h2460, 3, 1'b1);
        codes(12'h5A5, ZERO_SCALE);
        strobe();
        codes(12'h246, ZERO_SCALE);
        frame(CMD_UPDATE_DAC, 4'h8, 16'h0000, 3, 1'b1);
        codes(12'h246, 12'h246);
        load_strobe_n = 1'b0;
        tick(8);
        frame(CMD_WRITE_INPUT, 4'h1, 16'h1110, 3, 1'b1);
        codes(12'h111, 12'h246);
        load_strobe_n = 1'b1;
        tick(8);
        $display("test mask done");

        reset_level_select = 1'b1;
        frame(CMD_REF_SETUP, 4'h0, 16'h0001, 3, 1'b1);
        frame(CMD_WRITE_INPUT, 4'h8, 16'h3330, 3, 1'b1);
        frame(CMD_SOFT_RESET, 4'h0, 16'h0000, 3, 1'b1);
        check("por_busy", 12'h001, 12'(por_busy));
        wait_por();
        codes(MID_SCALE, MID_SCALE);
        check("ref_off", 12'h000, 12'(reference_off));
        strobe();
        codes(MID_SCALE, MID_SCALE);
        $display("test soft_reset done");
        complete_run();
    end
endmodule : drc_top_tb_top
